// ---- rtl/spi_diag_defs.svh ----
/*
 * Offsets, field positions, reset values and timing figures of the serial
 * diagnostic register interface. It holds definitions only.
 * It assumes that it is included by its bare name.
 */
`ifndef SPI_DIAG_DEFS_SVH
`define SPI_DIAG_DEFS_SVH

// register addresses (six-bit)
`define ADDR_MAIN_CONTROL     6'h00
`define ADDR_SENSE_CHAN_SEL   6'h03
`define ADDR_SENSE_RATIO_SEL  6'h04
`define ADDR_PULLUP_ENABLE    6'h07
`define ADDR_FAULT_STATUS     6'h32

// field positions
`define SENSE_ENABLE_BIT      3
`define GS_GLOBAL_ERR         7
`define GS_COMM_ERR           6
`define GS_NOT_RESET_ERR      5
`define GS_OFFSTATE_OPENLOAD  1
`define GS_FAIL_SAFE          0

// reset values, software reset command, info read data and frame length
`define RST_REG8              8'h00
`define SW_RESET_CMD          8'hFF
`define INFO_READ_DATA        8'h00
`define FRAME_BITS            5'h10

// timing
`define MCLK_MHZ              10
`define DIAG_DELAY_US         50
`define CSN_TIMEOUT_US        1000

`endif

// ---- rtl/spi_diag_pkg.sv ----
/*
 * Types of the serial diagnostic register interface.
 * It assumes spi_diag_defs.svh for the numbers it uses.
 */
package spi_diag_pkg;

	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_READ  = 2'h1,
		OP_RDCLR = 2'h2,
		OP_INFO  = 2'h3
	} opcode_t;

	// driver-side levels arriving from outside the clock domain
	typedef struct packed {
		logic [3:0] chanOn;
		logic [3:0] aboveThr;
		logic       sleepMode2;
	} pins_t;

	typedef struct packed {
		logic [2:0]       csnS;
		logic [2:0]       tglS;
		pins_t            pinS1;
		pins_t            pinS2;
		logic [7:0]       mainControl;
		logic [7:0]       senseChannelSelect;
		logic [7:0]       senseRatioSelect;
		logic [7:0]       offstatePullupEnable;
		logic [3:0]       offstateFaultStatus;
		logic [3:0][9:0]  diagCnt;
		logic [7:0]       readData;
		logic             failSafe;
		logic             commErr;
		logic             chipReset;
		logic [23:0]      tmo;
		logic             csSync;
	} state_t;

endpackage

// ---- rtl/spi_diag_register_interface.sv ----
/*
 * Serial 16-bit slave with register file, off-state open-load detection,
 * pull-up gating and current-sense selection of a quad high-side driver.
 * It assumes a mode 0 host, sck quiet while csnN is high for this device,
 * and at least five mclk periods between csnN rising and falling again.
 */
`timescale 1ns/1ps
`include "spi_diag_defs.svh"

module spi_diag_register_interface #(
	parameter int TIMEOUT_CYCLES = `CSN_TIMEOUT_US * `MCLK_MHZ
) (
	input  wire logic                mclk,
	input  wire logic                reset_n,
	input  wire logic                csnN,
	input  wire logic                sck,
	input  wire logic                sdi,
	output logic                     sdo,
	output logic                     sdoOe,
	input  wire spi_diag_pkg::pins_t drvPins,
	output logic [3:0]               pullupOn,
	output logic                     senseRoute,
	output logic [1:0]               senseChannel,
	output logic [3:0]               senseRatio,
	output logic                     csSync,
	output logic                     csSyncOe,
	output logic                     failSafeMode
);
	import spi_diag_pkg::*;

	localparam logic [9:0]  DIAG_DONE = 10'(`DIAG_DELAY_US * `MCLK_MHZ);
	localparam logic [23:0] TMO_LIM   = 24'(TIMEOUT_CYCLES);

	////////////////////////////////////////////////////////////////////////
	// frame-edge domain: csnN itself clocks start marker and frame capture

	logic        startTgl;
	logic        frameTgl;
	logic        frameOk;
	logic [15:0] frameData;
	logic        rxSeen;
	logic [4:0]  rxCnt;
	logic [15:0] rxShift;
	logic        txSeen;
	logic [3:0]  txIdx;
	logic [3:0]  txEff;
	logic [15:0] outWord;
	logic [7:0]  statusByte;

	always_ff @(negedge csnN or negedge reset_n) begin
		if (!reset_n) begin
			startTgl <= 1'b0;
		end else if (startTgl == rxSeen) begin
			// a frame without sck leaves the marker pending, so the next
			// frame still restarts both counters instead of resuming them
			startTgl <= ~startTgl;
		end
	end

	always_ff @(posedge csnN or negedge reset_n) begin
		if (!reset_n) begin
			frameTgl  <= 1'b0;
			frameOk   <= 1'b0;
			frameData <= 16'h0000;
		end else begin
			frameTgl  <= ~frameTgl;
			frameOk   <= (startTgl == rxSeen) && (rxCnt == `FRAME_BITS);
			frameData <= rxShift;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain on sck; counters restart at the first edge of a frame,
	// so nothing relies on sck running while select is high

	always_ff @(posedge sck or negedge reset_n) begin
		if (!reset_n) begin
			rxSeen  <= 1'b0;
			rxCnt   <= 5'h00;
			rxShift <= 16'h0000;
		end else if (startTgl != rxSeen) begin
			rxSeen  <= startTgl;
			rxCnt   <= 5'h01;
			rxShift <= {15'h0000, sdi};
		end else begin
			rxCnt   <= (rxCnt == 5'h1F) ? rxCnt : rxCnt + 5'h01;
			rxShift <= {rxShift[14:0], sdi};
		end
	end

	always_ff @(negedge sck or negedge reset_n) begin
		if (!reset_n) begin
			txSeen <= 1'b0;
			txIdx  <= 4'h0;
		end else if (startTgl != txSeen) begin
			txSeen <= startTgl;
			txIdx  <= 4'h1;
		end else begin
			txIdx  <= (txIdx == 4'hF) ? txIdx : txIdx + 4'h1;
		end
	end

	assign txEff   = (startTgl != txSeen) ? 4'h0 : txIdx;
	assign outWord = {statusByte, s.readData};
	// outWord is quasi-static: readData only changes between frames, open-load and fail-safe status bits at any mclk edge
	assign sdo     = outWord[~txEff];
	assign sdoOe   = ~csnN;

	////////////////////////////////////////////////////////////////////////
	// mclk domain

	state_t  s;
	state_t  n;
	logic    frameEv;
	logic    csnEdge;
	logic    validCmd;
	logic    swReset;
	opcode_t op;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic [3:0] setVec;
	logic [3:0] doneVec;

	assign frameEv  = s.tglS[2] ^ s.tglS[1];
	assign csnEdge  = s.csnS[2] ^ s.csnS[1];
	assign op       = opcode_t'(frameData[15:14]);
	assign addr     = frameData[13:8];
	assign wdata    = frameData[7:0];
	assign validCmd = frameEv && frameOk;
	assign swReset  = validCmd && (frameData[15:8] == `SW_RESET_CMD);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chan
			assign doneVec[gi] = (s.diagCnt[gi] == DIAG_DONE);
			assign setVec[gi]  = doneVec[gi] & ~s.pinS2.chanOn[gi] &
				s.pinS2.aboveThr[gi];
		end
	endgenerate

	always_comb begin
		n = s;
		n.csnS  = {s.csnS[1:0], csnN};
		n.tglS  = {s.tglS[1:0], frameTgl};
		n.pinS1 = drvPins;
		n.pinS2 = s.pinS1;
		for (int i = 0; i < 4; i++) begin
			if (s.pinS2.chanOn[i]) begin
				n.diagCnt[i] = 10'h000;
			end else if (s.diagCnt[i] != DIAG_DONE) begin
				n.diagCnt[i] = s.diagCnt[i] + 10'h001;
			end
		end
		if (csnEdge) begin
			n.tmo = 24'h000000;
		end else if (s.tmo != TMO_LIM) begin
			n.tmo = s.tmo + 24'h000001;
		end
		if (frameEv && !frameOk) begin
			n.commErr = 1'b1;
		end
		if (validCmd) begin
			n.commErr   = 1'b0;
			n.chipReset = 1'b0;
			n.failSafe  = 1'b0;
			case (op)
				OP_WRITE: begin
					if (addr == `ADDR_MAIN_CONTROL) begin
						n.mainControl = wdata;
					end else if (addr == `ADDR_SENSE_CHAN_SEL) begin
						n.senseChannelSelect = wdata;
					end else if (addr == `ADDR_SENSE_RATIO_SEL) begin
						n.senseRatioSelect = wdata;
					end else if (addr == `ADDR_PULLUP_ENABLE) begin
						n.offstatePullupEnable = wdata;
					end
				end
				OP_INFO: begin
					n.readData = `INFO_READ_DATA;
				end
				default: begin
					if (addr == `ADDR_MAIN_CONTROL) begin
						n.readData = s.mainControl;
					end else if (addr == `ADDR_SENSE_CHAN_SEL) begin
						n.readData = s.senseChannelSelect;
					end else if (addr == `ADDR_SENSE_RATIO_SEL) begin
						n.readData = s.senseRatioSelect;
					end else if (addr == `ADDR_PULLUP_ENABLE) begin
						n.readData = s.offstatePullupEnable;
					end else if (addr == `ADDR_FAULT_STATUS) begin
						n.readData = {4'h0, s.offstateFaultStatus};
					end else begin
						n.readData = `RST_REG8;
					end
					if (op == OP_RDCLR && addr == `ADDR_FAULT_STATUS) begin
						n.offstateFaultStatus = 4'h0;
					end
				end
			endcase
		end
		// timeout beats a frame clear in the same cycle
		if (s.tmo == TMO_LIM) begin
			n.failSafe = 1'b1;
		end
		if (swReset) begin
			n.mainControl          = `RST_REG8;
			n.senseChannelSelect   = `RST_REG8;
			n.senseRatioSelect     = `RST_REG8;
			n.offstatePullupEnable = `RST_REG8;
			n.offstateFaultStatus  = 4'h0;
			n.readData             = `RST_REG8;
			n.chipReset            = 1'b1;
		end
		n.offstateFaultStatus = n.offstateFaultStatus | setVec;
		n.csSync = s.pinS2.chanOn[s.senseChannelSelect[1:0]];
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s           <= '0;
			s.csnS      <= 3'h7;
			s.failSafe  <= 1'b1;
			s.chipReset <= 1'b1;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	always_comb begin
		statusByte = 8'h00;
		statusByte[`GS_OFFSTATE_OPENLOAD] = |s.offstateFaultStatus;
		statusByte[`GS_COMM_ERR]          = s.commErr;
		statusByte[`GS_NOT_RESET_ERR]     = ~(s.chipReset | s.commErr);
		statusByte[`GS_FAIL_SAFE]         = s.failSafe;
		statusByte[`GS_GLOBAL_ERR]        = |s.offstateFaultStatus |
			s.commErr | s.chipReset | s.failSafe;
	end

	assign pullupOn     = s.offstatePullupEnable[3:0] &
		~{4{s.pinS2.sleepMode2}};
	assign senseRoute   = s.mainControl[`SENSE_ENABLE_BIT];
	assign senseChannel = s.senseChannelSelect[1:0];
	assign senseRatio   = s.senseRatioSelect[3:0];
	assign csSync       = s.csSync;
	assign csSyncOe     = s.mainControl[`SENSE_ENABLE_BIT];
	assign failSafeMode = s.failSafe;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	chk_fault_set: assert property (
		(setVec != 4'h0) |=> ((s.offstateFaultStatus & $past(setVec)) ==
			$past(setVec)))
		else $error("detected fault not latched");
	chk_global_olo: assert property (
		(s.offstateFaultStatus != 4'h0) |->
			(statusByte[1] && statusByte[7]))
		else $error("global open-load or error flag missing");
	chk_diag_delay: assert property (
		((s.offstateFaultStatus & ~$past(s.offstateFaultStatus) &
			~$past(doneVec)) == 4'h0))
		else $error("fault set before diagnosis delay");
	chk_pullup_gate: assert property (
		$rose(s.pinS2.sleepMode2) |-> (pullupOn == 4'h0) ##1
			$stable(s.offstatePullupEnable))
		else $error("pull-ups not off in sleep mode 2");
	chk_sync_follow: assert property (
		s.mainControl[3] ##1 s.mainControl[3] |->
			(csSync == $past(s.pinS2.chanOn[s.senseChannelSelect[1:0]]))
			&& csSyncOe)
		else $error("sense sync does not follow selected output");
	chk_bad_frame: assert property (
		(frameEv && !frameOk) |=> (s.commErr && !statusByte[5]) ##1
			s.commErr)
		else $error("communication error not flagged");
	chk_sw_reset: assert property (
		swReset |=> (s.mainControl == 8'h00 &&
			s.offstatePullupEnable == 8'h00 && s.chipReset))
		else $error("software reset did not clear registers");
	chk_timeout_fs: assert property (
		(s.tmo == TMO_LIM && !frameEv) |=> (s.failSafe &&
			$stable(s.mainControl) && $stable(s.offstatePullupEnable)))
		else $error("timeout did not enter fail safe cleanly");
	chk_ro_fault: assert property (
		(validCmd && op == OP_WRITE && setVec == 4'h0) |=>
			$stable(s.offstateFaultStatus))
		else $error("fault status changed by a write");
	chk_commit_only: assert property (
		!validCmd |=> ($stable(s.mainControl) &&
			$stable(s.offstatePullupEnable)))
		else $error("register changed without a valid frame");
	chk_rdclr_fault: assert property (
		(validCmd && op == OP_RDCLR && addr == `ADDR_FAULT_STATUS) |=>
			(s.offstateFaultStatus == $past(setVec)))
		else $error("read and clear left stale fault bits");
	chk_pullup_awake: assert property (
		!s.pinS2.sleepMode2 |->
			(pullupOn == s.offstatePullupEnable[3:0]))
		else $error("enabled pull-up not driven while awake");
	chk_tmo_restart: assert property (
		csnEdge |=> (s.tmo == 24'h000000))
		else $error("select edge did not restart the timeout");

	cov_good_write: cover property (validCmd && op == OP_WRITE);
	cov_bad_frame: cover property (frameEv && !frameOk);
	cov_fault_clear: cover property (validCmd && op == OP_RDCLR &&
		addr == `ADDR_FAULT_STATUS);
	cov_timeout: cover property (s.tmo == TMO_LIM);
	cov_sleep_gate: cover property ($rose(s.pinS2.sleepMode2));

endmodule

// ---- tb/spi_host_model.sv ----
/*
 * Host side of the serial link: a mode 0 master that sends frames of
 * sixteen or fewer clocks and collects the reply.
 * It assumes the device drives sdo only while sdoOe is high.
 */
`timescale 1ns/1ps

module spi_host_model (
	output logic      csnN,
	output logic      sck,
	output logic      sdi,
	input  wire logic sdo,
	input  wire logic sdoOe
);
	localparam int HALF = 32;
	logic lastSdo;
	logic sdoWire;

	////////////////////////////////////////////////////////////////////
	// a released sdo shows the inverse of its last level, never a copy
	assign sdoWire = sdoOe ? sdo : ~lastSdo;

	always @(posedge sck) begin
		if (sdoOe) begin
			lastSdo <= sdo;
		end
	end

	initial begin
		csnN = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
		lastSdo = 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// short frames are allowed so the device refusal can be exercised
	task automatic xfer(input logic [15:0] word, input int nBits,
		output logic [15:0] rsp);
		int i;
		rsp = 16'h0000;
		sck = 1'b0;
		csnN = 1'b0;
		#HALF;
		for (i = 0; i < nBits; i++) begin
			sdi = word[15 - i];
			#HALF;
			// mode 0, sample reply on rising sck
			sck = 1'b1;
			rsp = {rsp[14:0], sdoWire};
			#HALF;
			sck = 1'b0;
		end
		#HALF;
		csnN = 1'b1;
		sdi = ~sdi;
		#600;
	endtask
endmodule

// ---- tb/tb_spi_diag_register_interface.sv ----
/*
 * Self-checking bench of the serial diagnostic register interface.
 * It assumes spi_host_model as the host and a short select timeout.
 */
`timescale 1ns/1ps
`include "spi_diag_defs.svh"

module tb_spi_diag_register_interface;
	import spi_diag_pkg::*;
	logic                mclk;
	logic                reset_n;
	logic                csnN;
	logic                sck;
	logic                sdi;
	logic                sdo;
	logic                sdoOe;
	pins_t               drvPins;
	logic [3:0]          pullupOn;
	logic                senseRoute;
	logic [1:0]          senseChannel;
	logic [3:0]          senseRatio;
	logic                csSync;
	logic                csSyncOe;
	logic                failSafeMode;
	logic [15:0]         rsp;
	logic [7:0]          rdData;
	int                  failCount;
	int                  checks;

	initial mclk = 1'b0;
	always begin
		#50;
		mclk = ~mclk;
	end

	spi_diag_register_interface #(.TIMEOUT_CYCLES(200)) dut (
		.mclk(mclk), .reset_n(reset_n), .csnN(csnN), .sck(sck),
		.sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .drvPins(drvPins),
		.pullupOn(pullupOn), .senseRoute(senseRoute),
		.senseChannel(senseChannel), .senseRatio(senseRatio),
		.csSync(csSync), .csSyncOe(csSyncOe),
		.failSafeMode(failSafeMode)
	);

	spi_host_model host (
		.csnN(csnN), .sck(sck), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe)
	);

	////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			failCount++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic xf(input logic [15:0] w);
		host.xfer(w, 16, rsp);
	endtask

	// reply to a read arrives in the following frame
	task automatic rd(input logic [5:0] a);
		xf({2'b01, a, 8'h00});
		xf(16'hC000);
		rdData = rsp[7:0];
	endtask

	task automatic waitClk(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask

	task automatic setPins(input logic [3:0] on, input logic [3:0] thr,
		input logic sl);
		@(posedge mclk);
		drvPins <= '{chanOn: on, aboveThr: thr, sleepMode2: sl};
		waitClk(5);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("oe idle", 16'h0000, {15'h0, sdoOe});
		xf(16'hC000);
		chk("status reset", 16'h0081, {8'h0, rsp[15:8]});
		xf(16'hC000);
		chk("status ok", 16'h0020, {8'h0, rsp[15:8]});
		chk("failsafe off", 16'h0000, {15'h0, failSafeMode});
	endtask

	task automatic t_regs;
		logic [5:0] adr [4];
		logic [7:0] dat [4];
		int i;
		adr = '{`ADDR_MAIN_CONTROL, `ADDR_SENSE_CHAN_SEL,
			`ADDR_SENSE_RATIO_SEL, `ADDR_PULLUP_ENABLE};
		dat = '{8'h08, 8'h02, 8'h0A, 8'h05};
		for (i = 0; i < 4; i++) begin
			xf({2'b00, adr[i], dat[i]});
		end
		xf(16'h1000);
		chk("route", 16'h0001, {15'h0, senseRoute});
		chk("chan", 16'h0002, {14'h0, senseChannel});
		chk("ratio", 16'h000A, {12'h0, senseRatio});
		chk("pullup", 16'h0005, {12'h0, pullupOn});
		for (i = 0; i < 4; i++) begin
			rd(adr[i]);
			chk("readback", {8'h0, dat[i]}, {8'h0, rdData});
		end
	endtask

	task automatic t_pins;
		setPins(4'h0, 4'h0, 1'b1);
		chk("sleep off", 16'h0000, {12'h0, pullupOn});
		setPins(4'h0, 4'h0, 1'b0);
		chk("wake on", 16'h0005, {12'h0, pullupOn});
		setPins(4'h4, 4'h0, 1'b0);
		chk("sync on", 16'h0003, {14'h0, csSync, csSyncOe});
		setPins(4'h0, 4'h0, 1'b0);
		chk("sync off", 16'h0001, {14'h0, csSync, csSyncOe});
	endtask

	task automatic t_bad;
		int n;
		int j;
		for (j = 0; j < 2; j++) begin
			n = (j == 0) ? 15 : 0;
			host.xfer(16'h070F, n, rsp);
			chk("short kept", 16'h0005, {12'h0, pullupOn});
			xf(16'hC000);
			chk("comm err", 16'h00C0, {8'h0, rsp[15:8]});
		end
		xf(16'hC000);
		chk("comm clear", 16'h0020, {8'h0, rsp[15:8]});
	endtask

	task automatic t_fault;
		setPins(4'h2, 4'h2, 1'b0);
		setPins(4'h0, 4'h2, 1'b0);
		waitClk(100);
		xf(16'hC000);
		chk("no early", 16'h0020, {8'h0, rsp[15:8]});
		waitClk(500);
		rd(`ADDR_FAULT_STATUS);
		chk("fault bit", 16'h0002, {8'h0, rdData});
		chk("fault glob", 16'h00A2, {8'h0, rsp[15:8]});
		setPins(4'h0, 4'h0, 1'b0);
		xf({2'b00, `ADDR_FAULT_STATUS, 8'h00});
		rd(`ADDR_FAULT_STATUS);
		chk("ro status", 16'h0002, {8'h0, rdData});
		xf({2'b10, `ADDR_FAULT_STATUS, 8'h00});
		rd(`ADDR_FAULT_STATUS);
		chk("cleared", 16'h0000, {8'h0, rdData});
	endtask

	task automatic t_timeout;
		waitClk(300);
		chk("timeout", 16'h0001, {15'h0, failSafeMode});
		chk("regs kept", 16'h0005, {12'h0, pullupOn});
		xf(16'hC000);
		chk("fs status", 16'h00A1, {8'h0, rsp[15:8]});
	endtask

	task automatic t_swreset;
		xf({`SW_RESET_CMD, 8'h00});
		chk("sw pull", 16'h0000, {12'h0, pullupOn});
		chk("sw route", 16'h0000, {14'h0, senseRoute, csSyncOe});
		xf(16'hC000);
		chk("sw status", 16'h0080, {8'h0, rsp[15:8]});
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// whole run needs well under 300 us; hang limit is generous
	initial begin
		#1000000;
		failCount++;
		wrap_up();
	end

	initial begin
		failCount = 0;
		checks = 0;
		reset_n = 1'b0;
		drvPins = '{chanOn: 4'h0, aboveThr: 4'h0, sleepMode2: 1'b0};
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		waitClk(3);
		t_reset();
		t_regs();
		t_pins();
		t_bad();
		t_fault();
		t_timeout();
		t_swreset();
		wrap_up();
	end
endmodule
